// ==== rtl/afe_pkg.sv ====
// Purpose: Shared constants for the converter control port and its master.
// Assumes: One 200 MHz clock drives both ends.
// Notes: Byte indices form a flat map of ten defined bytes.
package afe_pkg;

	// Control byte layout: device address, register index, direction.
	localparam int CTRL_DEV_HI = 7;
	localparam int CTRL_DEV_LO = 6;
	localparam int CTRL_IDX_HI = 5;
	localparam int CTRL_IDX_LO = 1;
	localparam int CTRL_RW_BIT = 0;

	// Byte indices of the register map.
	localparam logic [4:0] IDX_CH0_HI = 5'h00;
	localparam logic [4:0] IDX_CH0_LO = 5'h02;
	localparam logic [4:0] IDX_CH1_HI = 5'h03;
	localparam logic [4:0] IDX_CH1_LO = 5'h05;
	localparam logic [4:0] IDX_CFG1_HI = 5'h06;
	localparam logic [4:0] IDX_CFG1_LO = 5'h07;
	localparam logic [4:0] IDX_CFG2_HI = 5'h08;
	localparam logic [4:0] IDX_CFG2_LO = 5'h09;

	// First configuration register fields and reset value.
	localparam int CFG1_PRESCALE_LO = 14;
	localparam int CFG1_WIDTH0_BIT = 8;
	localparam int CFG1_WIDTH1_BIT = 9;
	localparam int CFG1_OVERSAMP_LO = 0;
	localparam logic [15:0] CFG1_RESET = 16'h0301;
	localparam logic [15:0] CFG1_MASK = 16'hC303;

	// Second configuration register fields and reset value.
	localparam int CFG2_CHRESET_LO = 0;
	localparam int CFG2_SHUTDOWN_LO = 2;
	localparam int CFG2_GROUP_LO = 6;
	localparam logic [15:0] CFG2_RESET = 16'h0040;
	localparam logic [15:0] CFG2_MASK = 16'h00CF;

	// Read group codes.
	localparam logic [1:0] GROUP_SINGLE = 2'h0;
	localparam logic [1:0] GROUP_REGISTER = 2'h1;
	localparam logic [1:0] GROUP_TYPE = 2'h2;
	localparam logic [1:0] GROUP_ALL = 2'h3;

	// Clock chain.
	localparam int SAMPLE_DIV = 4;
	localparam int OVERSAMP_BASE = 32;

	// Serial clock half period in system clocks, and its timing.
	localparam real CLOCK_PERIOD_NS = 5.0;
	localparam real SCK_HALF_NS = 40.0;
	localparam int SCK_HALF_CYC = int'(SCK_HALF_NS / CLOCK_PERIOD_NS);

	localparam logic [1:0] DEV_ADDR_RESET = 2'h0;

endpackage

// ==== rtl/afe_spi_device.sv ====
// Purpose: Converter control port with clock chain and result registers.
// Assumes: Link pins are sampled by the system clock through two flops.
// Notes: Serial clock must stay slower than an eighth of the system clock.
`timescale 1ns/100ps
module afe_spi_device
	import afe_pkg::*;
#(
	parameter logic [1:0] DEV_ADDR = DEV_ADDR_RESET
) (
	// System.
	input wire logic clock,
	input wire logic rst_b,
	// Link.
	afe_spi_if.device link,
	// Converter side.
	input wire logic [23:0] chResult0,
	input wire logic [23:0] chResult1,
	output logic analogTick,
	output logic sampleTick,
	output logic [1:0] chInReset,
	output logic [1:0] chShutdown
);

	typedef enum {PH_CTRL, PH_READ, PH_WRITE, PH_IGNORE} phase_t;

	phase_t phase_r;
	logic csS1, csS2, sckS1, sckS2, sckS3, sdiS1, sdiS2, hrS1, hrS2;
	logic sckRise, sckFall, frameOn;
	logic [2:0] bitCnt_r;
	logic [7:0] inSh_r;
	logic [7:0] inByte;
	logic [6:0] outSh_r;
	logic sdo_r;
	logic [4:0] addr_r;
	logic [15:0] cfg1_r, cfg2_r;
	logic [23:0] res0_r, res1_r;
	logic [2:0] preCnt_r;
	logic [1:0] quarterCnt_r;
	logic [7:0] overCnt_r;
	logic [7:0] preMax, overMax;
	logic rateTick, readyLow_r;

	// Two flops on every pin before logic looks at it.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{csS1, csS2} <= 2'h3;
			{sckS1, sckS2, sckS3} <= 3'h0;
			{sdiS1, sdiS2} <= 2'h0;
			{hrS1, hrS2} <= 2'h3;
		end else begin
			csS1 <= link.csN;
			csS2 <= csS1;
			sckS1 <= link.sck;
			sckS2 <= sckS1;
			sckS3 <= sckS2;
			sdiS1 <= link.mosi;
			sdiS2 <= sdiS1;
			hrS1 <= link.hardResetN;
			hrS2 <= hrS1;
		end
	end

	assign frameOn = !csS2;
	assign sckRise = frameOn && sckS2 && !sckS3;
	assign sckFall = frameOn && !sckS2 && sckS3;
	assign inByte = {inSh_r[6:0], sdiS2};

	// Clock chain: prescaler, fixed quarter, oversampling counter.
	assign preMax = 8'((1 << cfg1_r[CFG1_PRESCALE_LO +: 2]) - 1);
	assign overMax = 8'((OVERSAMP_BASE << cfg1_r[CFG1_OVERSAMP_LO +: 2]) - 1);
	assign rateTick = sampleTick && overCnt_r == overMax;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_r <= 3'h0;
			quarterCnt_r <= 2'h0;
			overCnt_r <= 8'h00;
			analogTick <= 1'b0;
			sampleTick <= 1'b0;
		end else if (!hrS2) begin
			preCnt_r <= 3'h0;
			quarterCnt_r <= 2'h0;
			overCnt_r <= 8'h00;
			analogTick <= 1'b0;
			sampleTick <= 1'b0;
		end else begin
			analogTick <= {5'h00, preCnt_r} >= preMax;
			preCnt_r <= ({5'h00, preCnt_r} >= preMax) ? 3'h0 : preCnt_r + 3'h1;
			sampleTick <= 1'b0;
			if (analogTick) begin
				quarterCnt_r <= quarterCnt_r + 2'h1;
				sampleTick <= quarterCnt_r == 2'(SAMPLE_DIV - 1);
			end
			if (sampleTick) begin
				overCnt_r <= (overCnt_r >= overMax) ? 8'h00 : overCnt_r + 8'h01;
			end
		end
	end

	// Results: reset clears, shutdown freezes, otherwise capture per rate.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			res0_r <= 24'h000000;
			res1_r <= 24'h000000;
		end else begin
			if (!hrS2 || chInReset[0]) begin
				res0_r <= 24'h000000;
			end else if (rateTick && !chShutdown[0]) begin
				res0_r <= chResult0;
			end
			if (!hrS2 || chInReset[1]) begin
				res1_r <= 24'h000000;
			end else if (rateTick && !chShutdown[1]) begin
				res1_r <= chResult1;
			end
		end
	end

	// Data ready: low for one sample period after each new result.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			readyLow_r <= 1'b0;
		end else if (!hrS2) begin
			readyLow_r <= 1'b0;
		end else if (rateTick && (chInReset | chShutdown) != 2'h3) begin
			readyLow_r <= 1'b1;
		end else if (sampleTick) begin
			readyLow_r <= 1'b0;
		end
	end

	assign link.dataReadyN = !readyLow_r;
	assign chInReset = cfg2_r[CFG2_CHRESET_LO +: 2];
	assign chShutdown = cfg2_r[CFG2_SHUTDOWN_LO +: 2];

	function automatic logic defined(input logic [4:0] idx);
		defined = idx <= IDX_CFG2_LO;
	endfunction

	// Byte at an index; a 16-bit result reads its low byte as zero.
	function automatic logic [7:0] readVal(input logic [4:0] idx);
		case (idx)
			5'h00: readVal = res0_r[23:16];
			5'h01: readVal = res0_r[15:8];
			5'h02: readVal = cfg1_r[CFG1_WIDTH0_BIT] ? res0_r[7:0] : 8'h00;
			5'h03: readVal = res1_r[23:16];
			5'h04: readVal = res1_r[15:8];
			5'h05: readVal = cfg1_r[CFG1_WIDTH1_BIT] ? res1_r[7:0] : 8'h00;
			5'h06: readVal = cfg1_r[15:8];
			5'h07: readVal = cfg1_r[7:0];
			5'h08: readVal = cfg2_r[15:8];
			5'h09: readVal = cfg2_r[7:0];
			default: readVal = 8'h00;
		endcase
	endfunction

	// Next index, wrapping inside the group chosen by the group field.
	function automatic logic [4:0] nextIdx(input logic [4:0] idx);
		logic [4:0] lo, hi;
		lo = idx;
		hi = idx;
		case (cfg2_r[CFG2_GROUP_LO +: 2])
			GROUP_SINGLE: begin
				lo = idx;
				hi = idx;
			end
			GROUP_REGISTER: begin
				if (idx <= IDX_CH0_LO) {lo, hi} = {IDX_CH0_HI, IDX_CH0_LO};
				else if (idx <= IDX_CH1_LO) {lo, hi} = {IDX_CH1_HI, IDX_CH1_LO};
				else if (idx <= IDX_CFG1_LO) {lo, hi} = {IDX_CFG1_HI, IDX_CFG1_LO};
				else {lo, hi} = {IDX_CFG2_HI, IDX_CFG2_LO};
			end
			GROUP_TYPE: begin
				if (idx <= IDX_CH1_LO) {lo, hi} = {IDX_CH0_HI, IDX_CH1_LO};
				else {lo, hi} = {IDX_CFG1_HI, IDX_CFG2_LO};
			end
			default: {lo, hi} = {IDX_CH0_HI, IDX_CFG2_LO};
		endcase
		if (!defined(idx)) nextIdx = idx;
		else nextIdx = (idx == hi) ? lo : idx + 5'h01;
	endfunction

	// Frame sequencing: bit count and phase restart on every frame.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= PH_CTRL;
			bitCnt_r <= 3'h0;
			inSh_r <= 8'h00;
		end else if (!frameOn) begin
			phase_r <= PH_CTRL;
			bitCnt_r <= 3'h0;
		end else if (sckRise) begin
			inSh_r <= inByte;
			bitCnt_r <= bitCnt_r + 3'h1;
			if (bitCnt_r == 3'h7 && phase_r == PH_CTRL) begin
				if (inByte[CTRL_DEV_HI:CTRL_DEV_LO] != DEV_ADDR) begin
					phase_r <= PH_IGNORE;
				end else if (inByte[CTRL_RW_BIT]) begin
					phase_r <= PH_READ;
				end else begin
					phase_r <= PH_WRITE;
				end
			end
		end
	end

	// Address counter and register writes; hard reset wins over writes.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_r <= 5'h00;
			cfg1_r <= CFG1_RESET;
			cfg2_r <= CFG2_RESET;
		end else begin
			if (sckRise && bitCnt_r == 3'h7 && phase_r == PH_CTRL) begin
				addr_r <= inByte[CTRL_IDX_HI:CTRL_IDX_LO];
			end else if (sckRise && bitCnt_r == 3'h7 && phase_r == PH_WRITE) begin
				addr_r <= nextIdx(addr_r);
			end else if (sckFall && bitCnt_r == 3'h0 && phase_r == PH_READ) begin
				addr_r <= nextIdx(addr_r);
			end
			if (!hrS2) begin
				cfg1_r <= CFG1_RESET;
				cfg2_r <= CFG2_RESET;
			end else if (sckRise && bitCnt_r == 3'h7 && phase_r == PH_WRITE) begin
				case (addr_r)
					IDX_CFG1_HI: cfg1_r[15:8] <= inByte & CFG1_MASK[15:8];
					IDX_CFG1_LO: cfg1_r[7:0] <= inByte & CFG1_MASK[7:0];
					IDX_CFG2_HI: cfg2_r[15:8] <= inByte & CFG2_MASK[15:8];
					IDX_CFG2_LO: cfg2_r[7:0] <= inByte & CFG2_MASK[7:0];
					default: cfg1_r <= cfg1_r;
				endcase
			end
		end
	end

	// Output shifter: a new byte is loaded on the first falling edge.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sdo_r <= 1'b0;
			outSh_r <= 7'h00;
		end else if (sckFall && phase_r == PH_READ) begin
			if (bitCnt_r == 3'h0) begin
				{sdo_r, outSh_r} <= readVal(addr_r);
			end else begin
				sdo_r <= outSh_r[6];
				outSh_r <= {outSh_r[5:0], 1'b0};
			end
		end
	end

	// Driven only inside a matched read frame.
	assign link.serialOutA = sdo_r;
	assign link.serialOutAOe = frameOn && phase_r == PH_READ;

endmodule

// ==== rtl/afe_spi_host.sv ====
// Purpose: Serial master that frames control and data bytes to the port.
// Assumes: Caller supplies a write byte whenever asked for one.
// Notes: The half period must cover the far end's pin synchronisers.
`timescale 1ns/100ps
module afe_spi_host
	import afe_pkg::*;
#(
	parameter int SCK_HALF = SCK_HALF_CYC
) (
	// System.
	input wire logic clock,
	input wire logic rst_b,
	// Link.
	afe_spi_if.host link,
	// Request.
	input wire logic start,
	input wire logic clockIdleHigh,
	input wire logic [1:0] devAddr,
	input wire logic [4:0] regIdx,
	input wire logic readNotWrite,
	input wire logic [4:0] byteCount,
	input wire logic [7:0] wrData,
	input wire logic hardResetReq,
	// Answer.
	output logic wrTake,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic busy,
	output logic dataReadyFall
);

	typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} hstate_t;

	hstate_t state_r;
	logic [7:0] halfCnt_r;
	logic halfDone;
	logic [2:0] bitCnt_r;
	logic [4:0] left_r;
	logic isCtrl_r, rw_r, idleHigh_r;
	logic [7:0] txSh_r, rxSh_r;
	logic misoS1, misoS2, drS1, drS2, drS3;
	logic csN_r, sck_r, mosi_r, hardResetN_r;

	assign halfDone = halfCnt_r == 8'(SCK_HALF - 1);
	assign busy = state_r != H_IDLE;

	// Pin inputs pass two flops.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{misoS1, misoS2} <= 2'h0;
			{drS1, drS2, drS3} <= 3'h7;
		end else begin
			misoS1 <= link.misoLine;
			misoS2 <= misoS1;
			drS1 <= link.dataReadyN;
			drS2 <= drS1;
			drS3 <= drS2;
		end
	end

	assign dataReadyFall = drS3 && !drS2;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hardResetN_r <= 1'b1;
		end else begin
			hardResetN_r <= !hardResetReq;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			halfCnt_r <= 8'h00;
		end else if (state_r == H_IDLE || halfDone) begin
			halfCnt_r <= 8'h00;
		end else begin
			halfCnt_r <= halfCnt_r + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= H_IDLE;
			csN_r <= 1'b1;
			sck_r <= 1'b0;
			mosi_r <= 1'b0;
			bitCnt_r <= 3'h0;
			left_r <= 5'h00;
			isCtrl_r <= 1'b0;
			rw_r <= 1'b0;
			idleHigh_r <= 1'b0;
			txSh_r <= 8'h00;
			rxSh_r <= 8'h00;
			rdData <= 8'h00;
			rdValid <= 1'b0;
			wrTake <= 1'b0;
		end else begin
			rdValid <= 1'b0;
			wrTake <= 1'b0;
			case (state_r)
				H_IDLE: begin
					sck_r <= clockIdleHigh;
					if (start) begin
						csN_r <= 1'b0;
						idleHigh_r <= clockIdleHigh;
						rw_r <= readNotWrite;
						left_r <= byteCount;
						isCtrl_r <= 1'b1;
						bitCnt_r <= 3'h0;
						txSh_r <= {devAddr, regIdx, readNotWrite};
						state_r <= H_SETUP;
					end
				end
				H_SETUP: if (halfDone) begin
					sck_r <= 1'b0;
					mosi_r <= txSh_r[7];
					state_r <= H_LOW;
				end
				H_LOW: if (halfDone) begin
					sck_r <= 1'b1;
					rxSh_r <= {rxSh_r[6:0], misoS2};
					state_r <= H_HIGH;
				end
				H_HIGH: if (halfDone) begin
					if (bitCnt_r != 3'h7) begin
						bitCnt_r <= bitCnt_r + 3'h1;
						sck_r <= 1'b0;
						mosi_r <= txSh_r[6];
						txSh_r <= {txSh_r[6:0], 1'b0};
						state_r <= H_LOW;
					end else begin
						rdValid <= !isCtrl_r && rw_r;
						rdData <= rxSh_r;
						isCtrl_r <= 1'b0;
						bitCnt_r <= 3'h0;
						if (left_r == 5'h00) begin
							sck_r <= idleHigh_r;
							state_r <= H_HOLD;
						end else begin
							left_r <= left_r - 5'h01;
							wrTake <= !rw_r;
							txSh_r <= rw_r ? 8'h00 : wrData;
							mosi_r <= rw_r ? 1'b0 : wrData[7];
							sck_r <= 1'b0;
							state_r <= H_LOW;
						end
					end
				end
				H_HOLD: if (halfDone) begin
					csN_r <= 1'b1;
					state_r <= H_GAP;
				end
				H_GAP: if (halfDone) begin
					state_r <= H_IDLE;
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	assign link.csN = csN_r;
	assign link.sck = sck_r;
	assign link.mosi = mosi_r;
	assign link.hardResetN = hardResetN_r;

endmodule

// ==== rtl/afe_spi_if.sv ====
// Purpose: Pin-level carrier between the converter port and its master.
// Assumes: The serial output line is pulled low while nobody drives it.
// Notes: The shared data line level is resolved here from the enable.
`timescale 1ns/100ps
interface afe_spi_if;
	logic csN;
	logic sck;
	logic mosi;
	logic serialOutA;
	logic serialOutAOe;
	logic misoLine;
	logic hardResetN;
	logic dataReadyN;

	assign misoLine = serialOutAOe ? serialOutA : 1'b0;

	modport device (
		input csN,
		input sck,
		input mosi,
		input hardResetN,
		output serialOutA,
		output serialOutAOe,
		output dataReadyN
	);

	modport host (
		output csN,
		output sck,
		output mosi,
		output hardResetN,
		input misoLine,
		input dataReadyN
	);
endinterface

// ==== tb/afe_spi_control_port_tb_top.sv ====
// Purpose: Drives master and port back to back and judges the answers.
// Assumes: Pull-down on the data line; default master half period.
// Notes: Gaps are measured between the first pair of events.
`timescale 1ns/100ps
module afe_spi_control_port_tb_top;
	import afe_pkg::*;
	logic clock, rst_b, start, clockIdleHigh, readNotWrite, hardResetReq;
	logic wrTake, rdValid, busy, analogTick, sampleTick, sawOe;
	logic dataReadyFall;
	logic [1:0] devAddr, chInReset, chShutdown;
	logic [4:0] regIdx, byteCount;
	logic [7:0] wrData, rdData;
	logic [23:0] chResult0, chResult1;
	logic [7:0] wq [8];
	logic [7:0] rq [$];
	int fail_count, comparisons, g, drf;
	afe_spi_if u_afe_spi_if ();
	afe_spi_device u_afe_spi_device (.clock(clock), .rst_b(rst_b),
		.link(u_afe_spi_if.device), .chResult0(chResult0),
		.chResult1(chResult1), .analogTick(analogTick),
		.sampleTick(sampleTick), .chInReset(chInReset),
		.chShutdown(chShutdown));
	afe_spi_host u_afe_spi_host (.clock(clock), .rst_b(rst_b),
		.link(u_afe_spi_if.host), .start(start),
		.clockIdleHigh(clockIdleHigh), .devAddr(devAddr), .regIdx(regIdx),
		.readNotWrite(readNotWrite), .byteCount(byteCount),
		.wrData(wrData), .hardResetReq(hardResetReq), .wrTake(wrTake),
		.rdData(rdData), .rdValid(rdValid), .busy(busy),
		.dataReadyFall(dataReadyFall));
	afe_spi_monitor u_afe_spi_monitor (.clock(clock), .rst_b(rst_b),
		.csN(u_afe_spi_if.csN), .sck(u_afe_spi_if.sck),
		.mosi(u_afe_spi_if.mosi), .serialOutA(u_afe_spi_if.serialOutA),
		.serialOutAOe(u_afe_spi_if.serialOutAOe),
		.misoLine(u_afe_spi_if.misoLine),
		.hardResetN(u_afe_spi_if.hardResetN),
		.dataReadyN(u_afe_spi_if.dataReadyN));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_val(input string nm, input int e, input int s);
		comparisons++;
		if (s != e) begin
			fail_count++;
			$display("ERROR %s expected %0d seen %0d", nm, e, s);
		end
	endtask
	// Next write byte is staged as soon as the previous one is taken.
	task automatic xfer(input logic md, input logic [1:0] dv,
		input logic [4:0] ix, input logic rw, input logic [4:0] n);
		int k;
		int t;
		k = 0;
		t = 0;
		rq = {};
		clockIdleHigh = md;
		// The idle level settles a cycle before the frame opens.
		@(posedge clock);
		#1 devAddr = dv;
		regIdx = ix;
		readNotWrite = rw;
		byteCount = n;
		wrData = wq[0];
		start = 1'b1;
		@(posedge clock);
		#1 start = 1'b0;
		while (busy !== 1'b0 && t < 30000) begin
			@(posedge clock);
			#1 t++;
			if (rdValid === 1'b1) rq.push_back(rdData);
			if (wrTake === 1'b1) k++;
			wrData = wq[k % 8];
		end
		if (t >= 30000) fail_count++;
	endtask
	task automatic rd(input logic md, input logic [1:0] dv,
		input logic [4:0] ix, input int n, input logic [31:0] e);
		xfer(md, dv, ix, 1'b1, n[4:0]);
		chk_val("read count", n, rq.size());
		for (int i = 0; i < n && i < rq.size(); i++) begin
			chk_byte("read byte", e[8 * (n - 1 - i) +: 8], rq[i]);
		end
	endtask
	task automatic wr(input logic md, input logic [4:0] ix,
		input logic [7:0] b);
		wq[0] = b;
		xfer(md, 2'h0, ix, 1'b0, 5'h01);
		wq[0] = 8'hFF;
	endtask
	// Cycles between two events; 5000 means none or only one was seen.
	task automatic gap(input int w, output int cnt);
		int n;
		logic p;
		logic hit;
		cnt = 0;
		n = 0;
		p = u_afe_spi_if.dataReadyN;
		while (n < 2 && cnt < 5000) begin
			@(posedge clock);
			#1 cnt++;
			hit = (w == 0) ? analogTick === 1'b1 : (w == 1) ?
				sampleTick === 1'b1 : p === 1'b1 &&
				u_afe_spi_if.dataReadyN === 1'b0;
			if (hit) n++;
			if (hit && n == 1) cnt = 0;
			p = u_afe_spi_if.dataReadyN;
		end
	endtask

	task automatic t_defaults();
		chk_byte("ch reset", 8'h00, {6'h00, chInReset});
		rd(1'b0, 2'h0, IDX_CFG1_HI, 2, 32'h0301);
		rd(1'b1, 2'h0, IDX_CFG2_HI, 2, 32'h0040);
		$display("test defaults done");
	endtask
	task automatic t_groups();
		logic [1:0] gc [4];
		logic [7:0] nx [4];
		logic [7:0] v;
		gc = '{2'h0, 2'h2, 2'h3, 2'h1};
		nx = '{8'h00, 8'h00, 8'h03, 8'hA5};
		for (int i = 0; i < 4; i++) begin
			v = {gc[i], 6'h00};
			wr(i[0], IDX_CFG2_LO, v);
			nx[0] = v;
			rd(i[0], 2'h0, IDX_CFG2_LO, 2, {16'h0000, v, nx[gc[i]]});
		end
		$display("test groups done");
	endtask
	task automatic t_results();
		rd(1'b0, 2'h0, IDX_CH0_HI, 3, 32'h00A5C33C);
		rd(1'b1, 2'h0, IDX_CH1_HI, 3, 32'h005A1E7F);
		wr(1'b0, IDX_CFG1_HI, 8'h02);
		gap(2, g);
		rd(1'b0, 2'h0, IDX_CH0_HI, 3, 32'h00A5C300);
		wr(1'b0, IDX_CFG1_HI, 8'h03);
		$display("test results done");
	endtask
	task automatic t_undef();
		rd(1'b1, 2'h0, 5'h1F, 3, 32'h0);
		xfer(1'b0, 2'h0, 5'h0A, 1'b0, 5'h02);
		rd(1'b0, 2'h0, IDX_CFG1_HI, 2, 32'h0301);
		rd(1'b0, 2'h0, IDX_CFG2_HI, 2, 32'h0040);
		$display("test undefined done");
	endtask
	task automatic t_addr();
		sawOe = 1'b0;
		rd(1'b0, 2'h1, IDX_CFG1_HI, 2, 32'h0);
		chk_byte("drive seen", 8'h00, {7'h00, sawOe});
		wq[0] = 8'h03;
		xfer(1'b0, 2'h2, IDX_CFG1_LO, 1'b0, 5'h01);
		wq[0] = 8'hFF;
		rd(1'b0, 2'h0, IDX_CFG1_LO, 1, 32'h01);
		$display("test address done");
	endtask
	task automatic t_channels();
		wr(1'b0, IDX_CFG2_LO, 8'h41);
		chk_byte("ch reset", 8'h01, {6'h00, chInReset});
		rd(1'b0, 2'h0, IDX_CH0_HI, 1, 32'h0);
		wr(1'b1, IDX_CFG2_LO, 8'h48);
		chk_byte("ch shutdown", 8'h02, {6'h00, chShutdown});
		wr(1'b0, IDX_CFG2_LO, 8'h4C);
		repeat (300) @(posedge clock);
		#1 drf = 0;
		gap(2, g);
		chk_val("idle gap", 5000, g);
		chk_val("idle host ready", 0, drf);
		wr(1'b0, IDX_CFG2_LO, 8'h40);
		gap(2, g);
		chk_val("ready gap", 256, g);
		chk_val("host ready seen", 1, int'(drf > 0));
		$display("test channels done");
	endtask
	task automatic t_clocks();
		for (int p = 0; p < 4; p++) begin
			wr(p[0], IDX_CFG1_HI, {p[1:0], 6'h03});
			gap(0, g);
			chk_val("analog gap", 1 << p, g);
			gap(1, g);
			chk_val("sample gap", 4 << p, g);
		end
		wr(1'b0, IDX_CFG1_HI, 8'h03);
		for (int r = 0; r < 4; r++) begin
			wr(r[0], IDX_CFG1_LO, {6'h00, r[1:0]});
			gap(2, g);
			chk_val("ready gap", 128 << r, g);
		end
		wr(1'b0, IDX_CFG1_LO, 8'h01);
		$display("test clocks done");
	endtask
	task automatic t_hard();
		wr(1'b1, IDX_CFG2_LO, 8'h41);
		wr(1'b0, IDX_CFG1_LO, 8'h02);
		hardResetReq = 1'b1;
		repeat (10) @(posedge clock);
		#1 hardResetReq = 1'b0;
		repeat (5) @(posedge clock);
		#1 chk_byte("ch reset", 8'h00, {6'h00, chInReset});
		rd(1'b0, 2'h0, IDX_CFG1_HI, 2, 32'h0301);
		$display("test hard reset done");
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (u_afe_spi_if.serialOutAOe === 1'b1) sawOe <= 1'b1;
		if (dataReadyFall === 1'b1) drf <= drf + 1;
	end
	// Tests need about 24000 cycles; this allows more than three times that.
	initial begin
		#400000;
		fail_count++;
		final_report();
	end
	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		clockIdleHigh = 1'b0;
		devAddr = 2'h0;
		regIdx = 5'h00;
		readNotWrite = 1'b0;
		byteCount = 5'h00;
		wrData = 8'h00;
		hardResetReq = 1'b0;
		sawOe = 1'b0;
		chResult0 = 24'hA5C33C;
		chResult1 = 24'h5A1E7F;
		for (int i = 0; i < 8; i++) wq[i] = 8'hFF;
		repeat (6) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clock);
		#1 t_defaults();
		t_groups();
		t_results();
		t_undef();
		t_addr();
		t_channels();
		t_clocks();
		t_hard();
		final_report();
	end
endmodule

// ==== tb/afe_spi_monitor.sv ====
// Purpose: Concurrent checks on the pins between the port and its master.
// Assumes: One clock domain; rst_b is the only reset.
// Notes: Bounds allow for the two-flop pin synchronisers of the port.
`timescale 1ns/100ps
module afe_spi_monitor (
	// System.
	input wire logic clock,
	input wire logic rst_b,
	// Pins.
	input wire logic csN,
	input wire logic sck,
	input wire logic mosi,
	input wire logic serialOutA,
	input wire logic serialOutAOe,
	input wire logic misoLine,
	input wire logic hardResetN,
	input wire logic dataReadyN
);
	logic [15:0] frameCnt_r;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Saturates, so a long frame can never wrap back under the bound.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			frameCnt_r <= 16'h0000;
		else if (csN)
			frameCnt_r <= 16'h0000;
		else if (frameCnt_r != 16'hFFFF)
			frameCnt_r <= frameCnt_r + 16'h0001;
	end

	property p_release_idle;
		csN [*5] |-> !serialOutAOe;
	endproperty
	a_release_idle: assert property (p_release_idle)
		else $error("data output driven while deselected");
	property p_no_carry;
		$fell(csN) |-> !serialOutAOe [*8];
	endproperty
	a_no_carry: assert property (p_no_carry)
		else $error("data output driven at frame start");
	property p_ctrl_first;
		$rose(serialOutAOe) |-> frameCnt_r >= 16'h0080;
	endproperty
	a_ctrl_first: assert property (p_ctrl_first)
		else $error("data output driven before control byte ended");
	property p_launch_fall;
		!csN && serialOutAOe && $changed(serialOutA) |-> !sck;
	endproperty
	a_launch_fall: assert property (p_launch_fall)
		else $error("data bit changed while serial clock high");
	property p_sample_rise;
		!csN && $rose(sck) |-> $stable(mosi);
	endproperty
	a_sample_rise: assert property (p_sample_rise)
		else $error("master data moved at serial clock rise");
	property p_idle_quiet;
		csN [*3] |-> $stable(serialOutA);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("data output moved while deselected");
	property p_dr_hard;
		!hardResetN [*4] |-> dataReadyN;
	endproperty
	a_dr_hard: assert property (p_dr_hard)
		else $error("data ready active during hard reset");
	property p_dr_width;
		$fell(dataReadyN) |-> ##[1:40] dataReadyN;
	endproperty
	a_dr_width: assert property (p_dr_width)
		else $error("data ready pulse too long");
	property p_dr_gap;
		$rose(dataReadyN) |-> dataReadyN [*8];
	endproperty
	a_dr_gap: assert property (p_dr_gap)
		else $error("data ready pulses too close");
endmodule
